// *** src/tmsc_defs.svh ***
// register offsets, reset values, field positions and timing counts
`ifndef TMSC_DEFS_SVH
`define TMSC_DEFS_SVH
`define TMSC_PTR_FLAGS_RD 8'h02
`define TMSC_PTR_CFG_RD 8'h03
`define TMSC_PTR_RATE_RD 8'h04
`define TMSC_PTR_CFG_WR 8'h09
`define TMSC_PTR_RATE_WR 8'h0A
`define TMSC_PTR_ONESHOT_WR 8'h0F
`define TMSC_PTR_RES 8'h1A
`define TMSC_PTR_CONSEC 8'h22
`define TMSC_CFG_RST 8'h00
`define TMSC_RATE_RST 8'h08
`define TMSC_RES_RST 8'h1C
`define TMSC_CONSEC_RST 8'h01
`define TMSC_CFG_MASK_BIT 7
`define TMSC_CFG_SD_BIT 6
`define TMSC_CFG_PFS_BIT 5
`define TMSC_CFG_RANGE_BIT 2
`define TMSC_CLK_HZ 20000000
`define TMSC_START_DELAY_US 10
`define TMSC_START_CYCLES ((`TMSC_START_DELAY_US * (`TMSC_CLK_HZ / 1000000)))
// conversion 9-bit time 12.5 ms, in microseconds
`define TMSC_CONV9_US 12500
`define TMSC_CONV9_CYCLES ((`TMSC_CONV9_US * (`TMSC_CLK_HZ / 1000000)))
// slowest period 16 s (0.0625 conv/s), in milliseconds
`define TMSC_PERIOD_SLOW_MS 16000
`define TMSC_PERIOD_SLOW_CYCLES ((`TMSC_PERIOD_SLOW_MS * (`TMSC_CLK_HZ / 1000)))
`endif

// *** src/tmsc_pkg.sv ***
// types shared by the status and configuration register bank
package tmsc_pkg;
  typedef struct packed {
    logic local_hi;
    logic local_lo;
    logic remote_hi;
    logic remote_lo;
    logic open;
    logic local_shut;
    logic remote_shut;
  } tmsc_cmp_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] ptr;
    logic [7:0] data;
  } tmsc_host_t;
  typedef enum logic [1:0] {TMSC_IDLE, TMSC_LOCAL, TMSC_REMOTE, TMSC_WAIT} tmsc_state_t;
endpackage

// *** src/tmsc_regs.sv ***
// status, configuration, resolution and pacing register bank
`timescale 1ns/1ns
`include "tmsc_defs.svh"
// Operation
// RULE1: flag register readable at 02h only; writes to it do nothing
// RULE2: bit 7 of flags is high while a conversion runs
// RULE3: open-sensor bit latches on remote conversions until flag read
// RULE4: shutdown flags set above limit, clear below limit minus hysteresis
// RULE5: with select at 0 upper-limit flags latch when limit exceeded
// RULE6: with select at 1 upper-limit flags are live comparators with hysteresis
// RULE7: lower-limit flags latch whenever crossed, independent of select
// RULE8: latched flags clear on flag read only if cause is gone
// RULE9: live flags update at conversion end, unaffected by reads
// RULE10: flag read leaves alert asserted; alert response releases it
// RULE11: in alert mode a rising latched flag drives alert low
// RULE12: configuration written at 09h, read at 03h, resets 00h
// RULE13: mask bit holds alert state but keeps pin high in alert mode
// RULE14: alert waits for programmed consecutive out-of-limit conversions
// RULE15: shutdown bit stops conversion at once; clearing resumes
// RULE16: one-shot write in shutdown starts exactly one conversion
// RULE17: select bit picks alert pin or second over-temperature output
// RULE18: first conversion starts automatically soon after reset
// RULE19: range bit picks standard or extended format
// RULE20: host writes zero into reserved configuration bits
// RULE21: resolution bits set local conversion time 12.5 to 100 ms
// RULE22: resolution register resets to 1Ch; host keeps fixed bits
// RULE23: rate register written 0Ah, read 04h, resets 08h, sets idle time
// RULE24: consecutive count selectable 1 to 4, default one
// RULE25: extended format offset, code 00h is -64 C
// RULE26: every write loads pointer; reads use last pointer
// RULE27: writes to read-only flag locations change nothing
module tmsc_regs #(
  parameter int START_CYCLES = `TMSC_START_CYCLES,
  parameter int CONV9_CYCLES = `TMSC_CONV9_CYCLES,
  parameter longint PERIOD_SLOW_CYCLES = `TMSC_PERIOD_SLOW_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // host register access from serial engine
  input wire tmsc_pkg::tmsc_host_t i_host,
  input wire logic i_alert_response,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_pointer,
  // converter results: comparator levels valid at conversion end
  input wire tmsc_pkg::tmsc_cmp_t i_cmp_above,
  input wire tmsc_pkg::tmsc_cmp_t i_cmp_clear,
  // converter control
  output logic o_conv_start,
  output logic o_conv_remote,
  output logic [1:0] o_local_res,
  output logic o_extended_range,
  // pins
  output logic o_alert_n,
  output logic o_busy
);
  import tmsc_pkg::*;

  logic [7:0] cfg;
  logic [7:0] rate;
  logic [7:0] res;
  logic [7:0] consec;
  logic [7:0] pointer;
  logic l_hi, l_lo, r_hi, r_lo, open_f, l_sh, r_sh;
  logic alert_state;
  tmsc_state_t state;
  logic [31:0] timer;
  logic [39:0] idle_cnt;
  logic oneshot_req;
  logic [2:0] cnt_l, cnt_r;
  logic conv_done;
  logic [7:0] flags;
  logic wr_cfg, wr_rate, wr_res, wr_consec, wr_oneshot, rd_flags;
  logic booted;
  logic [31:0] boot_cnt;
  logic local_trip, remote_trip;
  logic [2:0] need;

  // conversion time grows as a doubling of the 9-bit time
  function automatic logic [31:0] conv_cycles(input logic [1:0] r);
    conv_cycles = 32'(CONV9_CYCLES) << r;
  endfunction

  // period halves per rate step; codes above 6 pin at the fastest
  function automatic logic [39:0] period_cycles(input logic [7:0] code);
    logic [2:0] s;
    s = (code > 8'h06) ? 3'h6 : code[2:0];
    period_cycles = 40'(PERIOD_SLOW_CYCLES) >> s;
  endfunction

  assign wr_cfg = i_host.wr && i_host.ptr == `TMSC_PTR_CFG_WR;
  assign wr_rate = i_host.wr && i_host.ptr == `TMSC_PTR_RATE_WR;
  assign wr_res = i_host.wr && i_host.ptr == `TMSC_PTR_RES;
  assign wr_consec = i_host.wr && i_host.ptr == `TMSC_PTR_CONSEC;
  assign wr_oneshot = i_host.wr && i_host.ptr == `TMSC_PTR_ONESHOT_WR;
  assign rd_flags = i_host.rd && pointer == `TMSC_PTR_FLAGS_RD;
  assign conv_done = (state == TMSC_LOCAL || state == TMSC_REMOTE) && timer == 32'h0;

  // every write loads the pointer [RULE26]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pointer <= 8'h00;
    end else if (i_host.wr) begin
      pointer <= i_host.ptr;
    end
  end

  // flag pointer has no write decode, so such writes fall through [RULE1] [RULE27]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg <= `TMSC_CFG_RST; // [RULE12]
      rate <= `TMSC_RATE_RST; // [RULE23]
      res <= `TMSC_RES_RST; // [RULE22]
      consec <= `TMSC_CONSEC_RST; // [RULE24]
    end else begin
      if (wr_cfg) begin
        cfg <= i_host.data; // [RULE12] [RULE20]
      end
      if (wr_rate) begin
        rate <= i_host.data;
      end
      if (wr_res) begin
        res <= i_host.data;
      end
      if (wr_consec) begin
        consec <= i_host.data;
      end
    end
  end

  // power-up delay before the first conversion [RULE18]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      booted <= 1'b0;
      boot_cnt <= 32'h0;
    end else if (!booted) begin
      boot_cnt <= boot_cnt + 32'h1;
      booted <= boot_cnt >= 32'(START_CYCLES - 1);
    end
  end

  // one-shot only counts in shutdown; held until a conversion takes it [RULE16]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oneshot_req <= 1'b0;
    end else if (wr_oneshot && cfg[`TMSC_CFG_SD_BIT] && state == TMSC_IDLE) begin
      oneshot_req <= 1'b1;
    end else if (state != TMSC_IDLE || !cfg[`TMSC_CFG_SD_BIT]) begin
      oneshot_req <= 1'b0;
    end
  end

  // local then remote conversion, then idle wait set by rate [RULE15] [RULE21] [RULE23]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= TMSC_IDLE;
      timer <= 32'h0;
      idle_cnt <= 40'h0;
      o_conv_start <= 1'b0;
      o_conv_remote <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      if (cfg[`TMSC_CFG_SD_BIT] && !oneshot_req && state != TMSC_IDLE
          && !(state != TMSC_WAIT && idle_cnt[0])) begin
        state <= TMSC_IDLE; // stop at once [RULE15]
      end else begin
        case (state)
          TMSC_IDLE: begin
            if (booted && (!cfg[`TMSC_CFG_SD_BIT] || oneshot_req)) begin
              state <= TMSC_LOCAL;
              timer <= conv_cycles(res[1:0]) - 32'h1;
              idle_cnt <= {39'h0, cfg[`TMSC_CFG_SD_BIT]};
              o_conv_start <= 1'b1;
              o_conv_remote <= 1'b0;
            end
          end
          TMSC_LOCAL: begin
            if (timer == 32'h0) begin
              state <= TMSC_REMOTE;
              timer <= conv_cycles(2'h3) - 32'h1;
              o_conv_start <= 1'b1;
              o_conv_remote <= 1'b1;
            end else begin
              timer <= timer - 32'h1;
            end
          end
          TMSC_REMOTE: begin
            if (timer == 32'h0) begin
              if (idle_cnt[0]) begin
                state <= TMSC_IDLE;
                idle_cnt <= 40'h0;
              end else begin
                state <= TMSC_WAIT;
                idle_cnt <= period_cycles(rate);
              end
            end else begin
              timer <= timer - 32'h1;
            end
          end
          TMSC_WAIT: begin
            if (idle_cnt <= 40'(conv_cycles(res[1:0]) + conv_cycles(2'h3))) begin
              state <= TMSC_IDLE; // conversion time counts in the period
            end else begin
              idle_cnt <= idle_cnt - 40'h1;
            end
          end
          default: state <= TMSC_IDLE;
        endcase
      end
    end
  end

  // busy follows the converter [RULE2] [RULE9]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state == TMSC_LOCAL || state == TMSC_REMOTE);
    end
  end

  // hysteresis comparators, updated only at conversion end [RULE4] [RULE6] [RULE9]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      l_sh <= 1'b0;
      r_sh <= 1'b0;
    end else if (conv_done && state == TMSC_LOCAL) begin
      l_sh <= i_cmp_above.local_shut ? 1'b1 : (i_cmp_clear.local_shut ? 1'b0 : l_sh);
    end else if (conv_done) begin
      r_sh <= i_cmp_above.remote_shut ? 1'b1 : (i_cmp_clear.remote_shut ? 1'b0 : r_sh);
    end
  end

  // latched flags: set beats the read clear; clear only if cause gone [RULE3] [RULE5] [RULE7] [RULE8]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      l_hi <= 1'b0;
      l_lo <= 1'b0;
      r_hi <= 1'b0;
      r_lo <= 1'b0;
      open_f <= 1'b0;
    end else begin
      if (conv_done && state == TMSC_LOCAL) begin
        if (cfg[`TMSC_CFG_PFS_BIT]) begin
          l_hi <= i_cmp_above.local_hi ? 1'b1 : (i_cmp_clear.local_hi ? 1'b0 : l_hi); // [RULE6]
        end else if (i_cmp_above.local_hi) begin
          l_hi <= 1'b1;
        end else if (rd_flags) begin
          l_hi <= 1'b0;
        end
        l_lo <= i_cmp_above.local_lo || (l_lo && !rd_flags);
      end else if (rd_flags) begin
        if (!cfg[`TMSC_CFG_PFS_BIT] && !i_cmp_above.local_hi) begin
          l_hi <= 1'b0;
        end
        l_lo <= l_lo && i_cmp_above.local_lo;
      end
      // each channel sees the read even while the other one finishes
      if (conv_done && state == TMSC_REMOTE) begin
        if (cfg[`TMSC_CFG_PFS_BIT]) begin
          r_hi <= i_cmp_above.remote_hi ? 1'b1 : (i_cmp_clear.remote_hi ? 1'b0 : r_hi);
        end else if (i_cmp_above.remote_hi) begin
          r_hi <= 1'b1;
        end else if (rd_flags) begin
          r_hi <= 1'b0;
        end
        r_lo <= i_cmp_above.remote_lo || (r_lo && !rd_flags);
        open_f <= i_cmp_above.open || (open_f && !rd_flags); // remote only [RULE3]
      end else if (rd_flags) begin
        if (!cfg[`TMSC_CFG_PFS_BIT] && !i_cmp_above.remote_hi) begin
          r_hi <= 1'b0;
        end
        r_lo <= r_lo && i_cmp_above.remote_lo;
        open_f <= open_f && i_cmp_above.open;
      end
    end
  end

  // count 1..4 from thermometer code [RULE24]
  assign need = consec[3] ? 3'h4 : (consec[2] ? 3'h3 : (consec[1] ? 3'h2 : 3'h1));
  assign local_trip = i_cmp_above.local_hi || i_cmp_above.local_lo;
  assign remote_trip = i_cmp_above.remote_hi || i_cmp_above.remote_lo || i_cmp_above.open;

  // consecutive out-of-limit filter per channel [RULE14]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_l <= 3'h0;
      cnt_r <= 3'h0;
    end else if (conv_done && state == TMSC_LOCAL) begin
      cnt_l <= local_trip ? ((cnt_l < 3'h4) ? cnt_l + 3'h1 : cnt_l) : 3'h0;
    end else if (conv_done) begin
      cnt_r <= remote_trip ? ((cnt_r < 3'h4) ? cnt_r + 3'h1 : cnt_r) : 3'h0;
    end
  end

  // alert held until alert response, not by flag reads; new set beats release [RULE10] [RULE11]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      alert_state <= 1'b0;
    end else if (!cfg[`TMSC_CFG_PFS_BIT] && conv_done
                 && ((state == TMSC_LOCAL && local_trip && cnt_l + 3'h1 >= need)
                 || (state == TMSC_REMOTE && remote_trip && cnt_r + 3'h1 >= need))) begin
      alert_state <= 1'b1; // [RULE14]
    end else if (i_alert_response) begin
      alert_state <= 1'b0;
    end
  end

  // pin function and mask; second output follows upper-limit flags [RULE13] [RULE17]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_alert_n <= 1'b1;
    end else if (cfg[`TMSC_CFG_PFS_BIT]) begin
      o_alert_n <= !(l_hi || r_hi);
    end else begin
      o_alert_n <= !(alert_state && !cfg[`TMSC_CFG_MASK_BIT]);
    end
  end

  assign flags = {o_busy, l_hi, l_lo, r_hi, r_lo, open_f, r_sh, l_sh};

  // read data from last pointer; unmapped reads zero [RULE1] [RULE12] [RULE23]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= 8'h00;
    end else begin
      case (pointer)
        `TMSC_PTR_FLAGS_RD: o_rd_data <= flags;
        `TMSC_PTR_CFG_RD: o_rd_data <= cfg;
        `TMSC_PTR_RATE_RD: o_rd_data <= rate;
        `TMSC_PTR_RES: o_rd_data <= res;
        `TMSC_PTR_CONSEC: o_rd_data <= consec;
        default: o_rd_data <= 8'h00;
      endcase
    end
  end

  // format selection goes to the converter; limits in extended code offset by 64 [RULE19] [RULE25]
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_local_res <= 2'h0;
      o_extended_range <= 1'b0;
      o_pointer <= 8'h00;
    end else begin
      o_local_res <= res[1:0]; // [RULE21]
      o_extended_range <= cfg[`TMSC_CFG_RANGE_BIT];
      o_pointer <= pointer;
    end
  end
endmodule

// *** sim/tmsc_regs_assertions.sv ***
// concurrent checks on the status and configuration register bank ports
`timescale 1ns/1ns
module tmsc_regs_assertions #(
  parameter int START_CYCLES = 200
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // host side
  input wire tmsc_pkg::tmsc_host_t i_host,
  input wire logic i_alert_response,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_pointer,
  // converter and pins
  input wire logic o_conv_start,
  input wire logic o_extended_range,
  input wire logic o_alert_n,
  input wire logic o_busy
);
  import tmsc_pkg::*;
  localparam int START_MAX = START_CYCLES + 8;
  logic [7:0] cfg_sh;
  logic [8:0] os_age;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // shadow built from write strobes only, never from design outputs
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_sh <= 8'h00;
    end else if (i_host.wr && i_host.ptr == 8'h09) begin
      cfg_sh <= i_host.data;
    end
  end
  // saturating age of the last one-shot write
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      os_age <= 9'h1FF;
    end else if (i_host.wr && i_host.ptr == 8'h0F) begin
      os_age <= 9'h000;
    end else if (os_age != 9'h1FF) begin
      os_age <= os_age + 9'h001;
    end
  end
  sequence cfg_wr_s;
    i_host.wr && i_host.ptr == 8'h09;
  endsequence
  sequence quiet_s;
    !i_host.wr [*2];
  endsequence
  ptr_load_a: assert property (i_host.wr |-> ##2 o_pointer == $past(i_host.ptr, 2))
    else $error("pointer not loaded by write");
  start_busy_a: assert property ($rose(i_reset_n) |-> ##[1:START_MAX] o_busy)
    else $error("first conversion did not start");
  ext_range_a: assert property (cfg_wr_s ##1 quiet_s |-> o_extended_range == cfg_sh[2])
    else $error("range output differs from written bit");
  cfg_read_a: assert property ((o_pointer == 8'h03 && $past(o_pointer) == 8'h03
    && $stable(cfg_sh)) |-> o_rd_data == cfg_sh)
    else $error("configuration readback wrong");
  flags_busy_a: assert property ((o_pointer == 8'h02 && $past(o_pointer) == 8'h02)
    |-> o_rd_data[7] == $past(o_busy))
    else $error("busy flag differs from busy output");
  shutdown_stop_a: assert property ((i_host.wr && i_host.ptr == 8'h09 && i_host.data[6]
    && !cfg_sh[6]) |-> ##[1:3] !o_busy)
    else $error("shutdown did not stop conversion");
  no_free_conv_a: assert property ((o_conv_start && cfg_sh[6] && $past(cfg_sh[6], 4))
    |-> os_age < 9'h190)
    else $error("conversion started in shutdown without one-shot");
  alert_hold_a: assert property ((!o_alert_n && !cfg_sh[5] && !cfg_sh[7]
    && !i_alert_response && !$past(i_alert_response)
    && !i_host.wr && !$past(i_host.wr)) |=> !o_alert_n)
    else $error("alert released without alert response");
  alert_mask_a: assert property ((cfg_sh[7] && !cfg_sh[5]
    && $past(cfg_sh[7] && !cfg_sh[5], 2)) |-> o_alert_n)
    else $error("masked alert pin went low");
endmodule

bind tmsc_regs tmsc_regs_assertions #(.START_CYCLES(START_CYCLES)) tmsc_regs_assertions_inst (
  .i_ref_clk(i_ref_clk),
  .i_reset_n(i_reset_n),
  .i_host(i_host),
  .i_alert_response(i_alert_response),
  .o_rd_data(o_rd_data),
  .o_pointer(o_pointer),
  .o_conv_start(o_conv_start),
  .o_extended_range(o_extended_range),
  .o_alert_n(o_alert_n),
  .o_busy(o_busy)
);

// *** sim/tmsc_host_model.sv ***
// host-side model issuing register writes, reads and alert responses
`timescale 1ns/1ns
module tmsc_host_model (
  // clock
  input wire logic i_ref_clk,
  // register bank side
  input wire logic [7:0] i_rd_data,
  output tmsc_pkg::tmsc_host_t o_host,
  output logic o_alert_response
);
  import tmsc_pkg::*;
  initial begin
    o_host = '0;
    o_alert_response = 1'b0;
  end
  // strobe drops a full cycle before the next transfer may raise it
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data);
    @(negedge i_ref_clk);
    o_host.wr = 1'b1;
    o_host.ptr = ptr;
    o_host.data = data;
    if (ptr == 8'h09) o_host.data = data & 8'hE4;
    if (ptr == 8'h1A) o_host.data = (data & 8'h03) | 8'h1C;
    @(negedge i_ref_clk);
    o_host.wr = 1'b0;
    o_host.data = ~o_host.data;
  endtask
  // pointer loaded first whenever load is set, else the last pointer is used
  task automatic read_reg(input logic load, input logic [7:0] ptr, output logic [7:0] data);
    if (load) write_reg(ptr, 8'h00);
    repeat (2) @(negedge i_ref_clk);
    data = i_rd_data;
    o_host.rd = 1'b1;
    @(negedge i_ref_clk);
    o_host.rd = 1'b0;
  endtask
  task automatic alert_resp();
    @(negedge i_ref_clk);
    o_alert_response = 1'b1;
    @(negedge i_ref_clk);
    o_alert_response = 1'b0;
  endtask
endmodule

// *** sim/tmsc_regs_test.sv ***
// self-checking bench for the status and configuration register bank
`timescale 1ns/1ns
module tmsc_regs_test;
  import tmsc_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  tmsc_host_t host;
  logic alert_rsp;
  tmsc_cmp_t cmp_above = '0;
  tmsc_cmp_t cmp_clear = '0;
  logic [7:0] o_rd_data, o_pointer, rd_byte;
  logic o_conv_start, o_conv_remote, o_extended_range, o_alert_n, o_busy, prev;
  logic [1:0] o_local_res;
  int miscompares = 0;
  int checks = 0;
  int rises;
  int busy_cycles;
  // short counts keep the run small
  tmsc_regs #(.START_CYCLES(4), .CONV9_CYCLES(20), .PERIOD_SLOW_CYCLES(4000)) tmsc_regs_inst (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_host(host), .i_alert_response(alert_rsp),
    .o_rd_data(o_rd_data), .o_pointer(o_pointer), .i_cmp_above(cmp_above),
    .i_cmp_clear(cmp_clear), .o_conv_start(o_conv_start), .o_conv_remote(o_conv_remote),
    .o_local_res(o_local_res), .o_extended_range(o_extended_range), .o_alert_n(o_alert_n),
    .o_busy(o_busy));
  tmsc_host_model tmsc_host_model_inst (.i_ref_clk(i_ref_clk), .i_rd_data(o_rd_data),
    .o_host(host), .o_alert_response(alert_rsp));
  initial begin
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_byte(name, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic host_wr(input logic [7:0] ptr, input logic [7:0] data);
    tmsc_host_model_inst.write_reg(ptr, data);
  endtask
  task automatic rd_chk(input logic load, input logic [7:0] ptr, input string name,
                        input logic [7:0] exp, input logic [7:0] mask);
    tmsc_host_model_inst.read_reg(load, ptr, rd_byte);
    chk_byte(name, exp, rd_byte & mask);
  endtask
  // bounded wait; a hang ends the run as a failure
  task automatic wait_busy(input logic level);
    int n;
    n = 0;
    while (o_busy !== level && n < 3000) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n == 3000) begin
      miscompares++;
      $display("MISMATCH busy wait expected %b seen timeout", level);
      give_verdict();
    end
  endtask
  task automatic one_conv(input logic shot);
    if (shot) host_wr(8'h0F, 8'h00);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask
  initial begin
    repeat (20) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    wait_busy(1'b1);
    chk_byte("res out", 8'h00, {6'h00, o_local_res});
    rd_chk(1'b1, 8'h03, "cfg reset", 8'h00, 8'hFF);
    rd_chk(1'b1, 8'h04, "rate reset", 8'h08, 8'hFF);
    rd_chk(1'b1, 8'h02, "flags busy", 8'h80, 8'h80);
    $display("reset values done");
    host_wr(8'h09, 8'h04);
    rd_chk(1'b1, 8'h03, "cfg", 8'h04, 8'hFF);
    chk_bit("ext range", 1'b1, o_extended_range);
    host_wr(8'h02, 8'hFF);
    rd_chk(1'b1, 8'h03, "cfg after ro write", 8'h04, 8'hFF);
    rd_chk(1'b1, 8'h02, "flags after ro write", 8'h00, 8'h7F);
    host_wr(8'h0A, 8'h05);
    rd_chk(1'b1, 8'h04, "rate", 8'h05, 8'hFF);
    host_wr(8'h1A, 8'h03);
    rd_chk(1'b0, 8'h1A, "res", 8'h1F, 8'hFF);
    chk_byte("res out", 8'h03, {6'h00, o_local_res});
    host_wr(8'h1A, 8'h00);
    host_wr(8'h09, 8'h00);
    $display("registers done");
    cmp_above.local_lo = 1'b1;
    one_conv(1'b0);
    one_conv(1'b0);
    chk_bit("alert latched", 1'b0, o_alert_n);
    cmp_above = '0;
    one_conv(1'b0);
    rd_chk(1'b1, 8'h02, "flags latched", 8'h20, 8'h7F);
    rd_chk(1'b1, 8'h02, "flags cleared", 8'h00, 8'h7F);
    chk_bit("alert after read", 1'b0, o_alert_n);
    tmsc_host_model_inst.alert_resp();
    repeat (2) @(negedge i_ref_clk);
    chk_bit("alert released", 1'b1, o_alert_n);
    $display("latched flags done");
    host_wr(8'h09, 8'h40);
    repeat (4) @(negedge i_ref_clk);
    chk_bit("busy in shutdown", 1'b0, o_busy);
    prev = 1'b0;
    host_wr(8'h0F, 8'h00);
    rises = 0;
    busy_cycles = 0;
    for (int i = 0; i < 800; i++) begin
      @(negedge i_ref_clk);
      if (o_busy === 1'b1 && !prev) rises++;
      if (o_busy === 1'b1) busy_cycles++;
      prev = o_busy;
    end
    chk_byte("one-shot count", 8'h01, rises[7:0]);
    chk_byte("one-shot length", 8'hB4, busy_cycles[7:0]);
    host_wr(8'h09, 8'hC0);
    cmp_above.local_lo = 1'b1;
    one_conv(1'b1);
    cmp_above = '0;
    rd_chk(1'b1, 8'h02, "masked flags", 8'h20, 8'h7F);
    chk_bit("alert masked", 1'b1, o_alert_n);
    $display("shutdown done");
    cmp_above.local_shut = 1'b1;
    one_conv(1'b1);
    rd_chk(1'b1, 8'h02, "shut set", 8'h01, 8'h7F);
    cmp_above = '0;
    one_conv(1'b1);
    rd_chk(1'b1, 8'h02, "shut hold", 8'h01, 8'h7F);
    cmp_clear.local_shut = 1'b1;
    one_conv(1'b1);
    rd_chk(1'b1, 8'h02, "shut clear", 8'h00, 8'h7F);
    cmp_clear = '0;
    $display("shutdown flags done");
    host_wr(8'h09, 8'hE0);
    cmp_above.local_hi = 1'b1;
    one_conv(1'b1);
    chk_bit("second output", 1'b0, o_alert_n);
    cmp_above = '0;
    one_conv(1'b1);
    rd_chk(1'b1, 8'h02, "live high", 8'h40, 8'h7F);
    rd_chk(1'b1, 8'h02, "live high held", 8'h40, 8'h7F);
    cmp_clear.local_hi = 1'b1;
    one_conv(1'b1);
    rd_chk(1'b1, 8'h02, "live high clear", 8'h00, 8'h7F);
    chk_bit("second output off", 1'b1, o_alert_n);
    $display("second output done");
    host_wr(8'h09, 8'h40);
    host_wr(8'h22, 8'h02);
    rd_chk(1'b0, 8'h22, "consec", 8'h02, 8'hFF);
    tmsc_host_model_inst.alert_resp();
    cmp_above.local_lo = 1'b1;
    one_conv(1'b1);
    chk_bit("alert after one", 1'b1, o_alert_n);
    one_conv(1'b1);
    chk_bit("alert after two", 1'b0, o_alert_n);
    cmp_above = '0;
    $display("consecutive count done");
    give_verdict();
  end
endmodule
